// ===== cspap_pkg.sv
// Shared constants, register map and carrier types of the slave-port arbiter
`default_nettype none
package cspap_pkg;

  // Masters competing for the one slave port
  localparam int NM = 4;
  localparam int MW = 2;

  // Register byte offsets
  localparam logic [7:0] ADDR_MGC_BASE = 8'h00;
  localparam logic [7:0] MGC_STRIDE = 8'h04;
  localparam logic [7:0] ADDR_PRIO = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;

  // Field positions
  localparam int BAP_LSB = 0;
  localparam int PRIO_STRIDE = 4;
  localparam int CTRL_PARK_LSB = 0;
  localparam int CTRL_PMODE_LSB = 4;
  localparam int CTRL_ARB_BIT = 8;
  localparam int STAT_GRANT_LSB = 0;
  localparam int STAT_LAST_LSB = 8;
  localparam int STAT_HELD_BIT = 16;

  // Burst arbitration point codes
  localparam logic [2:0] BAP_NONE = 3'h0;
  localparam logic [2:0] BAP_EVERY = 3'h1;
  localparam logic [2:0] BAP_FOUR = 3'h2;
  localparam logic [2:0] BAP_EIGHT = 3'h3;
  localparam logic [2:0] BAP_SIXTEEN = 3'h4;
  localparam logic [4:0] BEATS_FOUR = 5'h04;
  localparam logic [4:0] BEATS_EIGHT = 5'h08;
  localparam logic [4:0] BEATS_SIXTEEN = 5'h10;
  localparam logic [4:0] BEAT_FIRST = 5'h01;

  // Parking control codes
  localparam logic [1:0] PMODE_FIXED = 2'h0;
  localparam logic [1:0] PMODE_LAST = 2'h1;
  localparam logic [1:0] PMODE_NONE = 2'h2;

  // Reset values
  localparam logic [2:0] BAP_RST = 3'h0;
  localparam logic [1:0] PARK_RST = 2'h0;
  localparam logic [1:0] PMODE_RST = 2'h0;
  localparam logic ARB_RST = 1'b0;
  localparam logic [7:0] PRIO_RST = 8'he4;

  // Bus transfer type bit that marks an active transfer
  localparam int HTRANS_ACT_BIT = 1;

  // Port state, one-hot
  typedef enum logic [1:0] {
    ST_OPEN = 2'b01,
    ST_HELD = 2'b10
  } cspap_state_e;

  // One master's current beat towards the port
  typedef struct packed {
    logic req;
    logic undef;
    logic last;
  } cspap_mreq_s;

  // Software configuration
  typedef struct packed {
    logic [NM-1:0][2:0] bap;
    logic [NM-1:0][MW-1:0] prio;
    logic [MW-1:0] park;
    logic [1:0] pmode;
    logic rr;
  } cspap_cfg_s;

  // Port state seen by software
  typedef struct packed {
    logic [NM-1:0] grant;
    logic [MW-1:0] last_user;
    logic held;
  } cspap_stat_s;

endpackage
`default_nettype wire

// ===== cspap_regs.sv
// AHB-Lite register slave holding the arbiter configuration and status view
`default_nettype none
module cspap_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output var cspap_pkg::cspap_cfg_s cfg,
  input wire cspap_pkg::cspap_stat_s stat
);
  import cspap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic wr_pend_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Address captured in the write address phase
  logic addr_take; // Address phase taken this cycle
  cspap_cfg_s cfg_r;

  // Only word transfers are issued, so hsize is not decoded
  assign addr_take = hsel & hready & htrans[HTRANS_ACT_BIT];

  // Read word mux; unmapped and reserved bits read as zero
  function automatic logic [31:0] rd_word(input logic [7:0] a, input cspap_cfg_s c,
                                          input cspap_stat_s s);
    logic [31:0] w;
    w = 32'h0;
    for (int i = 0; i < NM; i++) begin
      if (a == 8'(ADDR_MGC_BASE + MGC_STRIDE * i)) begin
        w[BAP_LSB +: 3] = c.bap[i];
      end
      if (a == ADDR_PRIO) begin
        w[PRIO_STRIDE * i +: MW] = c.prio[i];
      end
    end
    if (a == ADDR_CTRL) begin
      w[CTRL_PARK_LSB +: MW] = c.park;
      w[CTRL_PMODE_LSB +: 2] = c.pmode;
      w[CTRL_ARB_BIT] = c.rr;
    end
    if (a == ADDR_STAT) begin
      w[STAT_GRANT_LSB +: NM] = s.grant;
      w[STAT_LAST_LSB +: MW] = s.last_user;
      w[STAT_HELD_BIT] = s.held;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address phase capture; zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      wr_pend_r <= addr_take & hwrite;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_take) begin
        wr_addr_r <= haddr[7:0];
      end
      // Read data sampled at the address edge, stands through the data phase
      if (addr_take & ~hwrite) begin
        hrdata <= rd_word(haddr[7:0], cfg_r, stat);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-master burst arbitration points, port priority and control registers;
  // one process so the packed configuration struct keeps a single driver
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NM; i++) begin
        cfg_r.bap[i] <= BAP_RST;
      end
      cfg_r.prio <= PRIO_RST;
      cfg_r.park <= PARK_RST;
      cfg_r.pmode <= PMODE_RST;
      cfg_r.rr <= ARB_RST;
    end else if (wr_pend_r) begin
      for (int i = 0; i < NM; i++) begin
        if (wr_addr_r == 8'(ADDR_MGC_BASE + MGC_STRIDE * i)) begin
          cfg_r.bap[i] <= hwdata[BAP_LSB +: 3];
        end
      end
      if (wr_addr_r == ADDR_PRIO) begin
        for (int i = 0; i < NM; i++) begin
          cfg_r.prio[i] <= hwdata[PRIO_STRIDE * i +: MW];
        end
      end
      if (wr_addr_r == ADDR_CTRL) begin
        cfg_r.park <= hwdata[CTRL_PARK_LSB +: MW];
        cfg_r.pmode <= hwdata[CTRL_PMODE_LSB +: 2];
        cfg_r.rr <= hwdata[CTRL_ARB_BIT];
      end
    end
  end

  assign cfg = cfg_r;

endmodule
`default_nettype wire

// ===== cspap_arbiter.sv
// Slave-port arbiter with mid-burst arbitration points and idle parking
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module cspap_arbiter (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire cspap_pkg::cspap_mreq_s [cspap_pkg::NM-1:0] m_in,
  output logic [cspap_pkg::NM-1:0] grant,
  output logic port_held
);
  import cspap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  cspap_cfg_s cfg; // Software configuration
  cspap_stat_s stat; // Status view for software
  cspap_state_e state_r; // Open for arbitration or held by a transfer
  cspap_state_e state_nxt;
  logic [NM-1:0] grant_r; // Current owner or parked master, one-hot; zero when the port is left unparked
  logic [NM-1:0] grant_nxt;
  logic [MW-1:0] last_user_r; // Master that last had a beat accepted
  logic [MW-1:0] last_user_nxt;
  logic [4:0] beat_cnt_r; // Beats of the running undefined burst
  logic [4:0] beat_cnt_nxt;
  logic [NM-1:0] req_vec; // Masters presenting a beat
  logic [NM-1:0] acc_vec; // Beat accepted this cycle
  logic [NM-1:0] cand; // Candidates for the next grant
  logic [NM-1:0] winner;
  logic [NM-1:0] park_oh; // Where an idle port goes
  logic [MW-1:0] own; // Index of the granted master
  logic beat_acc;
  logic own_undef;
  logic own_last;
  logic [4:0] beat_num; // Number of the beat being accepted
  logic mid_point; // Accepted beat is an arbitration point
  logic end_xfer; // Accepted beat closes its transfer
  logic open_nxt; // Port may be re-arbitrated after this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  cspap_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .cfg(cfg),
    .stat(stat)
  );

  assign stat.grant = grant_r;
  assign stat.last_user = last_user_r;
  assign stat.held = (state_r == ST_HELD);

  ////////////////////////////////////////////////////////////////////////////
  // One-hot to index
  function automatic logic [MW-1:0] oh2idx(input logic [NM-1:0] oh);
    logic [MW-1:0] idx;
    idx = '0;
    for (int i = 0; i < NM; i++) begin
      if (oh[i]) begin
        idx = MW'(i);
      end
    end
    return idx;
  endfunction

  // Index to one-hot
  function automatic logic [NM-1:0] idx2oh(input logic [MW-1:0] idx);
    logic [NM-1:0] oh;
    oh = '0;
    oh[idx] = 1'b1;
    return oh;
  endfunction

  // Fixed priority: lowest priority value wins, ties go to the lower index
  function automatic logic [NM-1:0] pick_fixed(input logic [NM-1:0] c,
                                               input logic [NM-1:0][MW-1:0] p);
    logic [NM-1:0] oh;
    oh = '0;
    for (int lvl = NM - 1; lvl >= 0; lvl--) begin
      for (int i = NM - 1; i >= 0; i--) begin
        if (c[i] && p[i] == MW'(lvl)) begin
          oh = idx2oh(MW'(i));
        end
      end
    end
    return oh;
  endfunction

  // Round robin: the search starts just after the master that last had a beat accepted
  function automatic logic [NM-1:0] pick_rr(input logic [NM-1:0] c,
                                            input logic [MW-1:0] last);
    logic [NM-1:0] oh;
    logic [MW-1:0] idx;
    oh = '0;
    for (int k = NM; k >= 1; k--) begin
      idx = MW'(last + MW'(k));
      if (c[idx]) begin
        oh = idx2oh(idx);
      end
    end
    return oh;
  endfunction

  // Does this beat number sit on an arbitration point for the setting
  function automatic logic at_point(input logic [2:0] bap, input logic [4:0] n);
    logic hit;
    hit = 1'b0;
    case (bap)
      BAP_EVERY: hit = 1'b1;
      BAP_FOUR: hit = (n == BEATS_FOUR);
      BAP_EIGHT: hit = (n == BEATS_EIGHT);
      BAP_SIXTEEN: hit = (n == BEATS_SIXTEEN);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Gather the request bits of every master
  for (genvar g = 0; g < NM; g++) begin : g_req
    assign req_vec[g] = m_in[g].req;
  end

  // A beat is accepted when its master already holds the grant
  assign acc_vec = req_vec & grant_r;
  assign beat_acc = |acc_vec;
  assign own = oh2idx(grant_r);
  assign own_undef = m_in[own].undef;
  assign own_last = m_in[own].last;

  // First beat after an open port or a re-grant counts as beat one
  assign beat_num = (state_r == ST_HELD) ? 5'(beat_cnt_r + BEAT_FIRST) : BEAT_FIRST;
  assign mid_point = own_undef & at_point(cfg.bap[own], beat_num);
  assign end_xfer = beat_acc & own_last;

  ////////////////////////////////////////////////////////////////////////////
  // Boundary detection and port state
  always_comb begin
    state_nxt = state_r;
    open_nxt = 1'b0;
    unique case (state_r)
      ST_OPEN: begin
        // Idle, closing or arbitration-point beat leaves it open; else a transfer starts
        open_nxt = ~beat_acc | end_xfer | mid_point;
      end
      ST_HELD: begin
        // Wait states of the owner keep the port held
        open_nxt = end_xfer | (beat_acc & mid_point);
      end
      default: begin
        open_nxt = 1'b1;
      end
    endcase
    state_nxt = open_nxt ? ST_OPEN : ST_HELD;
  end

  // Beat counter for mid-burst points
  always_comb begin
    beat_cnt_nxt = 5'h00;
    if (!open_nxt) begin
      beat_cnt_nxt = beat_acc ? beat_num : beat_cnt_r;
    end
  end

  // Last user follows every accepted beat
  assign last_user_nxt = beat_acc ? own : last_user_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next owner: a finished master no longer competes, a paused burst does
  always_comb begin
    cand = req_vec & ~(end_xfer ? grant_r : '0);
    // Both schemes hand a lone candidate the port
    winner = cfg.rr ? pick_rr(cand, last_user_nxt) : pick_fixed(cand, cfg.prio);
    unique case (cfg.pmode)
      PMODE_FIXED: park_oh = idx2oh(cfg.park);
      PMODE_LAST: park_oh = idx2oh(last_user_nxt);
      PMODE_NONE: park_oh = '0;
      default: park_oh = idx2oh(cfg.park);
    endcase
    if (!open_nxt) begin
      grant_nxt = grant_r;
    end else if (cand != '0) begin
      grant_nxt = winner;
    end else begin
      grant_nxt = park_oh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant and port state; reset parks on master 0
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      grant_r <= 4'h1;
      state_r <= ST_OPEN;
    end else begin
      grant_r <= grant_nxt;
      state_r <= state_nxt;
    end
  end

  // Burst beat counting
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      beat_cnt_r <= 5'h00;
    end else begin
      beat_cnt_r <= beat_cnt_nxt;
    end
  end

  // Last user tracking for park-on-last and round robin
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_user_r <= 2'h0;
    end else begin
      last_user_r <= last_user_nxt;
    end
  end

  assign grant = grant_r;
  assign port_held = state_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_idle;
    state_r == ST_OPEN && req_vec == '0;
  endsequence

  // Parked owner presents a beat that opens a longer transfer, others may wait
  sequence s_own_start;
    acc_vec == grant_r && grant_r != '0 && !own_last && !mid_point;
  endsequence

  chk_grant_onehot: assert property ($onehot0(grant_r))
    else $error("grant not one-hot");
  chk_park_fixed: assert property (s_idle ##0 cfg.pmode == PMODE_FIXED |=>
    grant_r == idx2oh($past(cfg.park)))
    else $error("fixed park target missed");
  chk_park_last: assert property (s_idle ##0 cfg.pmode == PMODE_LAST |=>
    grant_r == idx2oh($past(last_user_r)))
    else $error("not parked on last user");
  chk_park_none: assert property (s_idle ##0 cfg.pmode == PMODE_NONE |=> grant_r == '0)
    else $error("port parked under no parking");
  chk_parked_start: assert property (s_idle ##1 s_own_start |=> port_held)
    else $error("parked master did not start at once");
  chk_switch_one: assert property (state_r == ST_OPEN && acc_vec == '0 &&
    $onehot(req_vec) |=> grant_r == $past(req_vec))
    else $error("foreign request not granted after one clock");
  chk_no_arb_hold: assert property (beat_acc && own_undef && !own_last &&
    cfg.bap[own] == BAP_NONE |=> grant_r == $past(grant_r) && port_held)
    else $error("undefined burst lost the port");
  chk_every_beat: assert property (beat_acc && own_undef &&
    cfg.bap[own] == BAP_EVERY |=> !port_held)
    else $error("no boundary after beat");
  chk_four_beats: assert property (beat_acc && own_undef && !own_last &&
    cfg.bap[own] == BAP_FOUR && beat_num != BEATS_FOUR |=> port_held)
    else $error("boundary before fourth beat");
  chk_fixed_burst: assert property (beat_acc && !own_undef && !own_last
    |=> grant_r == $past(grant_r) && port_held)
    else $error("fixed burst pre-empted");
  chk_cnt_restart: assert property (state_r == ST_OPEN && beat_acc && own_undef &&
    !own_last && !mid_point |=> beat_cnt_r == BEAT_FIRST)
    else $error("beat count did not restart");

endmodule
`default_nettype wire

// ===== cspap_master_model.sv
// Behavioural model of the four bus masters presenting beats to the slave port
`default_nettype none
module cspap_master_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] go,
  input wire logic [3:0] undef,
  input wire logic [3:0][4:0] len,
  input wire logic [3:0] grant,
  output var cspap_pkg::cspap_mreq_s [3:0] m_in,
  output logic [3:0] done,
  output logic [3:0][3:0] waitc,
  output logic [3:0][5:0] first_at
);
  import cspap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][4:0] sent_r; // Beats accepted so far per master
  logic [3:0] pend_r; // Master still has beats to present
  logic [3:0] got_r; // First beat already accepted
  logic [5:0] total_r; // Beats accepted by anyone since the last launch
  logic [3:0] acc; // Beat accepted this cycle

  assign acc = pend_r & grant;

  ////////////////////////////////////////////////////////////////////////////////
  // Beat presentation; fields are zero while idle so nothing stale is shown
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      m_in[i].req = pend_r[i];
      m_in[i].undef = pend_r[i] & undef[i];
      m_in[i].last = pend_r[i] & (sent_r[i] == len[i] - 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Beat bookkeeping; a request is held until the beat is accepted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sent_r <= '0;
      pend_r <= '0;
      got_r <= '0;
      total_r <= '0;
      done <= '0;
      waitc <= '0;
      first_at <= '0;
    end else begin
      // Count restarts at every launch so orders can be compared
      if (|go) begin
        total_r <= '0;
      end else begin
        total_r <= total_r + {5'h00, |acc};
      end
      for (int i = 0; i < 4; i++) begin
        if (go[i]) begin
          pend_r[i] <= 1'b1;
          sent_r[i] <= '0;
          got_r[i] <= 1'b0;
          done[i] <= 1'b0;
          waitc[i] <= '0;
        end else if (acc[i]) begin
          sent_r[i] <= sent_r[i] + 5'h01;
          got_r[i] <= 1'b1;
          if (!got_r[i]) begin
            first_at[i] <= total_r;
          end
          if (m_in[i].last) begin
            pend_r[i] <= 1'b0;
            done[i] <= 1'b1;
          end
        end else if (pend_r[i] && !got_r[i]) begin
          waitc[i] <= waitc[i] + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_crossbar_slave_port_arbitration_parking.sv
// Self-checking bench for the slave-port arbiter: registers, parking, burst arbitration
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_crossbar_slave_port_arbitration_parking;
  timeunit 1ns;
  timeprecision 1ps;
  import cspap_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic [31:0] hwdata = '0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  cspap_mreq_s [NM-1:0] m_in;
  logic [NM-1:0] grant;
  logic port_held;
  logic [3:0] go = '0;
  logic [3:0] undef = '0;
  logic [3:0][4:0] len = '0;
  logic [3:0] done;
  logic [3:0][3:0] waitc;
  logic [3:0][5:0] first_at;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] q;
  // One entry per burst case: arbitration point code, beats before master 0 wins
  logic [2:0] bcode [6] = '{BAP_NONE, BAP_EVERY, BAP_FOUR, BAP_EIGHT, BAP_SIXTEEN,
    BAP_EVERY};
  logic [5:0] bexp [6] = '{6'h14, 6'h01, 6'h04, 6'h08, 6'h10, 6'h04};

  assign hready = hreadyout; // Single slave drives the bus ready

  always #4 core_clk = ~core_clk;

  cspap_arbiter dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .m_in(m_in), .grant(grant),
    .port_held(port_held));

  cspap_master_model masters (.core_clk(core_clk), .resetn(resetn), .go(go), .undef(undef),
    .len(len), .grant(grant), .m_in(m_in), .done(done), .waitc(waitc), .first_at(first_at));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task close_out();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite single word transfer; request held until ready is seen high
  task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h00000000);
    `CHK(q, exp)
    `CHK(hresp, 1'b0)
  endtask

  // Launch the masters in the mask together and wait until all have finished
  task run(input logic [3:0] m);
    @(posedge core_clk);
    go <= m;
    @(posedge core_clk);
    go <= '0;
    do @(negedge core_clk); while ((done & m) !== m);
    repeat (2) @(negedge core_clk);
  endtask

  // A lone single transfer from one master
  task single(input int i);
    len[i] <= 5'h01;
    undef[i] <= 1'b0;
    run(4'h1 << i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    `CHK(grant, 4'b0001)
    `CHK(port_held, 1'b0)
    rd(8'h14, 32'h00000000);
    rd(8'h10, 32'h00003210);
    rd(8'h0c, 32'h00000000);
    rd(8'h40, 32'h00000000);
    // Parked master starts at once, any other pays one clock
    single(0);
    `CHK(waitc[0], 4'h0)
    single(1);
    `CHK(waitc[1], 4'h1)
    `CHK(grant, 4'b0001)
    rd(8'h18, 32'h00000101);
    // Fixed parking moved to master 2
    wr(8'h14, 32'h00000002);
    single(1);
    `CHK(grant, 4'b0100)
    single(2);
    `CHK(waitc[2], 4'h0)
    // Park on the last user
    wr(8'h14, 32'h00000010);
    single(3);
    `CHK(waitc[3], 4'h1)
    `CHK(grant, 4'b1000)
    single(3);
    `CHK(waitc[3], 4'h0)
    // No parking: idle port owned by nobody
    wr(8'h14, 32'h00000020);
    rd(8'h14, 32'h00000020);
    repeat (2) @(negedge core_clk);
    `CHK(grant, 4'b0000)
    single(0);
    `CHK(waitc[0] != 4'h0, 1'b1)
    // Master 3 bursts while master 0, of higher priority, waits for a boundary
    wr(8'h14, 32'h00000003);
    for (int k = 0; k < 6; k++) begin
      wr(8'h0c, {29'h00000000, bcode[k]});
      len[3] <= (k == 5) ? 5'h04 : 5'h14;
      undef[3] <= (k != 5);
      len[0] <= 5'h01;
      undef[0] <= 1'b0;
      run(4'b1001);
      `CHK(first_at[0], bexp[k])
    end
    // Round robin: after master 2 the next in turn is master 3
    wr(8'h14, 32'h00000120);
    single(2);
    len[1] <= 5'h01;
    len[3] <= 5'h01;
    undef[3] <= 1'b0;
    run(4'b1010);
    `CHK(first_at[3], 6'h00)
    `CHK(first_at[1], 6'h01)
    // Fixed priority: master 1 outranks master 3
    wr(8'h14, 32'h00000020);
    single(2);
    run(4'b1010);
    `CHK(first_at[1], 6'h00)
    close_out();
  end
endmodule
`default_nettype wire
